//--- bench/scb_bank_checker.sv
// assertion checker for the system configuration bank ports
// assumes: bound onto scb_bank, one clock, clk_en lowered by the bench only while the bus is idle
`timescale 1ns/1ns

module scb_bank_checker
  import scb_pkg::*;
#(
  parameter int LINES = 16  // external interrupt lines
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             clk_en,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [LINES-1:0] port_a_pin,
  input wire logic [LINES-1:0] port_b_pin,
  input scb_map_t              boot_area_map,
  input wire logic             i2c_pad_drive_select,
  input wire logic             i2c_scl_drive_high,
  input wire logic [LINES-1:0] irq_line_source_select
);
  // ****************************************************************
  // handshake sequences
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address and data of one write taken together
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
  endsequence
  // read address taken
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready && clk_en;
  endsequence
  a_write_answer: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_map_legal: assert property (boot_area_map inside {SCB_MAP_MAIN_FLASH, SCB_MAP_SYS_FLASH, SCB_MAP_RAM})
    else $error("boot map not one-hot");
  a_scl_follows_pad: assert property (clk_en |=> i2c_scl_drive_high == $past(i2c_pad_drive_select))
    else $error("clock drive not tracking pad bit");
  a_line_needs_pin: assert property ($past(clk_en) |-> (irq_line_source_select & ~$past(port_a_pin | port_b_pin)) == '0)
    else $error("interrupt line high with no pin high");
endmodule

bind scb_bank scb_bank_checker #(.LINES(LINES)) scb_bank_checker_i (.*);

//--- bench/test_scb_bank.sv
// self-checking bench for the system configuration bank
// assumes: scb_pkg and scb_cfg.svh compiled first, checker bound
`timescale 1ns/1ns
`include "scb_cfg.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module test_scb_bank;
  import scb_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic aclk, aresetn, clk_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [15:0] port_a_pin, port_b_pin, irq_line_source_select;
  scb_map_t boot_area_map;
  logic i2c_pad_drive_select, i2c_scl_drive_high;
  int n_mismatch = 0;   // mismatches seen
  int check_count = 0;  // comparisons made
  int cyc = 0;          // cycle count for the hang guard
  logic [3:0] sel [16]; // selector codes the bench expects
  logic [15:0] irq_held; // lines captured before clk_en drops
  int late = 0;         // cycles before bready or rready rises
  logic [7:0] offs [6] = '{`SCB_OFS_REMAP, `SCB_OFS_SRC0, `SCB_OFS_SRC1,
                           `SCB_OFS_SRC2, `SCB_OFS_SRC3, `SCB_OFS_PAD};
  logic [31:0] sd [4] = '{32'h0000_2010, 32'h0000_1F01, 32'h0000_0110, 32'h0000_1001};

  scb_bank scb_bank_i (.*);

  // clock and hang guard
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (late == 0);
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (late > 0) begin
      repeat (late) @(posedge aclk);
      s_axi_bready <= 1'b1;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask

  // one read compared with the expected word
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (late == 0);
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    if (late > 0) begin
      repeat (late) @(posedge aclk);
      s_axi_rready <= 1'b1;
    end
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rdata", ed, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask

  // expected interrupt lines from pins and selector codes
  function automatic logic [15:0] exp_irq();
    logic [15:0] e;
    for (int n = 0; n < 16; n++) begin
      e[n] = (sel[n] == `SCB_SEL_PORT_A) ? port_a_pin[n] :
             (sel[n] == `SCB_SEL_PORT_B) ? port_b_pin[n] : 1'b0;
    end
    return e;
  endfunction

  // counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    aclk = 0;
    aresetn = 0;
    clk_en = 1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    port_a_pin = 16'hA5C3;
    port_b_pin = 16'h3C5A;
    foreach (sel[n]) sel[n] = 4'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // every register reads zero; map starts at main flash, interrupt lines follow port A
    foreach (offs[i]) rd(offs[i], `SCB_RST_WORD, `SCB_RESP_OKAY);
    `CHK("map", SCB_MAP_MAIN_FLASH, boot_area_map)
    `CHK("pad", 1'b0, i2c_pad_drive_select)
    `CHK("irq", port_a_pin, irq_line_source_select)
    // selectors: packing, undefined codes, reserved half written as zero
    for (int i = 0; i < 4; i++) begin
      wr(offs[i+1], sd[i], `SCB_RESP_OKAY);
      rd(offs[i+1], {16'h0, sd[i][15:0]}, `SCB_RESP_OKAY);
      for (int j = 0; j < 4; j++) sel[4*i+j] = sd[i][4*j+:4];
    end
    // one byte lane only: lines 12 and 13 change, 14 and 15 keep
    s_axi_wstrb <= 4'h1;
    wr(`SCB_OFS_SRC3, 32'h0000_00FF, `SCB_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`SCB_OFS_SRC3, 32'h0000_10FF, `SCB_RESP_OKAY);
    sel[12] = 4'hF;
    sel[13] = 4'hF;
    repeat (2) @(posedge aclk);
    `CHK("irq", exp_irq(), irq_line_source_select)
    port_a_pin <= ~port_a_pin;
    port_b_pin <= ~port_b_pin;
    repeat (3) @(posedge aclk);
    `CHK("irq", exp_irq(), irq_line_source_select)
    // frozen clock enable: lines hold while the pins move
    irq_held = irq_line_source_select;
    clk_en <= 1'b0;
    port_a_pin <= 16'h0000;
    port_b_pin <= 16'h0000;
    repeat (3) @(posedge aclk);
    `CHK("frozen", irq_held, irq_line_source_select)
    clk_en <= 1'b1;
    // every remap pattern
    for (int v = 0; v < 4; v++) begin
      wr(`SCB_OFS_REMAP, {30'h0, v[1:0]}, `SCB_RESP_OKAY);
      rd(`SCB_OFS_REMAP, {30'h0, v[1:0]}, `SCB_RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK("map", (v[0] == 1'b0) ? SCB_MAP_MAIN_FLASH : (v[1] ? SCB_MAP_RAM : SCB_MAP_SYS_FLASH), boot_area_map)
    end
    // pad drive select both ways, port only ever a controller here
    wr(`SCB_OFS_PAD, 32'h0001_0000, `SCB_RESP_OKAY);
    rd(`SCB_OFS_PAD, 32'h0001_0000, `SCB_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("pad", 1'b1, i2c_pad_drive_select)
    `CHK("scl", 1'b1, i2c_scl_drive_high)
    wr(`SCB_OFS_PAD, 32'h0000_0000, `SCB_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("pad", 1'b0, i2c_pad_drive_select)
    `CHK("scl", 1'b0, i2c_scl_drive_high)
    // unmapped places refused
    wr(8'h04, 32'hFFFF_FFFF, `SCB_RESP_SLVERR);
    rd(8'h04, 32'h0, `SCB_RESP_SLVERR);
    rd(8'h1C, 32'h0, `SCB_RESP_SLVERR);
    // late bready and rready: the answer must stand until taken
    late = 3;
    wr(`SCB_OFS_SRC0, 32'h0000_0011, `SCB_RESP_OKAY);
    rd(`SCB_OFS_SRC0, 32'h0000_0011, `SCB_RESP_OKAY);
    late = 0;
    // second reset clears written state
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SCB_OFS_SRC0, `SCB_RST_WORD, `SCB_RESP_OKAY);
    `CHK("map", SCB_MAP_MAIN_FLASH, boot_area_map)
    wrap_up();
  end
endmodule

//--- logic/scb_bank.sv
// system configuration register bank behind an axi4-lite slave
// assumes: one clock aclk, synchronous active-low aresetn, port pins already synchronised
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns

module scb_bank
  import scb_pkg::*;
#(
  parameter int LINES = 16  // external interrupt lines
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [LINES-1:0]  port_a_pin,
  input  wire logic [LINES-1:0]  port_b_pin,
  output scb_map_t               boot_area_map,
  output logic                   i2c_pad_drive_select,
  output logic                   i2c_scl_drive_high,
  output logic [LINES-1:0]       irq_line_source_select
);

  // ****************************************************************
  // decoding helpers
  // ****************************************************************

  // index of a selector register, or -1 when the offset is not one
  function automatic int src_index(input logic [7:0] addr);
    unique case (addr)
      `SCB_OFS_SRC0: src_index = 0;
      `SCB_OFS_SRC1: src_index = 1;
      `SCB_OFS_SRC2: src_index = 2;
      `SCB_OFS_SRC3: src_index = 3;
      default:       src_index = -1;
    endcase
  endfunction

  // true for any mapped word address
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == `SCB_OFS_REMAP) || (addr == `SCB_OFS_PAD) || (src_index(addr) >= 0);
  endfunction

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        m[8*b +: 8] = wd[8*b +: 8];
      end
    end
    merge = m;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [`SCB_REMAP_W-1:0] remap_reg,   remap_next;     // boot area remap field
  logic [`SCB_SRC_W-1:0]   src_reg [4];                 // selector registers
  logic [`SCB_SRC_W-1:0]   src_next [4];
  logic                    pad_reg,     pad_next;       // i2c pad drive bit
  scb_wr_state_t           wst_reg,     wst_next;       // write channel state
  logic                    aw_got_reg,  aw_got_next;    // address held
  logic                    w_got_reg,   w_got_next;     // data held
  logic [7:0]              awa_reg,     awa_next;       // held write address
  logic [31:0]             wd_reg,      wd_next;        // held write data
  logic [3:0]              ws_reg,      ws_next;        // held strobes
  logic [1:0]              bresp_reg,   bresp_next;     // write response code
  logic                    rvalid_reg,  rvalid_next;    // read data valid
  logic [31:0]             rdata_reg,   rdata_next;     // read data
  logic [1:0]              rresp_reg,   rresp_next;     // read response code
  scb_map_t                map_reg,     map_next;       // decoded remap output
  logic [LINES-1:0]        irq_reg,     irq_next;       // routed interrupt lines
  logic                    scl_hi_reg,  scl_hi_next;    // push-pull clock high drive
  logic                    awrdy_reg,   awrdy_next;     // write address ready
  logic                    wrdy_reg,    wrdy_next;      // write data ready
  logic                    bvalid_reg,  bvalid_next;    // write response valid
  logic                    arrdy_reg,   arrdy_next;     // read address ready

  // ****************************************************************
  // write channel and register update
  // ****************************************************************

  // combinational next state for write path and registers
  always_comb begin
    logic [31:0] word;
    int          idx;
    word        = `SCB_RST_WORD;
    idx         = -1;
    wst_next    = wst_reg;
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awa_next    = awa_reg;
    wd_next     = wd_reg;
    ws_next     = ws_reg;
    bresp_next  = bresp_reg;
    remap_next  = remap_reg;
    pad_next    = pad_reg;
    for (int i = 0; i < 4; i++) begin
      src_next[i] = src_reg[i];
    end
    unique case (wst_reg)
      SCB_WR_IDLE: begin
        // take address and data in either order
        if (s_axi_awvalid && !aw_got_reg) begin
          aw_got_next = 1'b1;
          awa_next    = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_reg) begin
          w_got_next = 1'b1;
          wd_next    = s_axi_wdata;
          ws_next    = s_axi_wstrb;
        end
        // both held: commit and offer response
        if (aw_got_reg && w_got_reg) begin
          idx         = src_index({awa_reg[7:2], 2'b00});
          aw_got_next = 1'b0;
          w_got_next  = 1'b0;
          wst_next    = SCB_WR_RESP;
          bresp_next  = is_mapped({awa_reg[7:2], 2'b00}) ? `SCB_RESP_OKAY : `SCB_RESP_SLVERR;
          if ({awa_reg[7:2], 2'b00} == `SCB_OFS_REMAP) begin
            // reserved bits dropped
            word       = merge({{(32-`SCB_REMAP_W){1'b0}}, remap_reg}, wd_reg, ws_reg);
            remap_next = word[`SCB_REMAP_W-1:0];
          end else if ({awa_reg[7:2], 2'b00} == `SCB_OFS_PAD) begin
            word     = merge({15'h0000, pad_reg, 16'h0000}, wd_reg, ws_reg);
            pad_next = word[`SCB_PAD_BIT];
          end else if (idx >= 0) begin
            word = merge({16'h0000, src_reg[idx[1:0]]}, wd_reg, ws_reg);
            src_next[idx[1:0]] = word[`SCB_SRC_W-1:0];
          end
        end
      end
      SCB_WR_RESP: begin
        // hold response until taken
        if (s_axi_bready) begin
          wst_next = SCB_WR_IDLE;
        end
      end
    endcase
    // handshake outputs registered from the next state, so they leave flops
    awrdy_next  = (wst_next == SCB_WR_IDLE) && !aw_got_next;
    wrdy_next   = (wst_next == SCB_WR_IDLE) && !w_got_next;
    bvalid_next = (wst_next == SCB_WR_RESP);
  end

  // register write-path state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_reg    <= SCB_WR_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awa_reg    <= 8'h00;
      wd_reg     <= `SCB_RST_WORD;
      ws_reg     <= 4'h0;
      bresp_reg  <= `SCB_RESP_OKAY;
      awrdy_reg  <= 1'b1;
      wrdy_reg   <= 1'b1;
      bvalid_reg <= 1'b0;
      remap_reg  <= '0;
      pad_reg    <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        src_reg[i] <= '0;
      end
    end else if (clk_en) begin
      wst_reg    <= wst_next;
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      awa_reg    <= awa_next;
      wd_reg     <= wd_next;
      ws_reg     <= ws_next;
      bresp_reg  <= bresp_next;
      awrdy_reg  <= awrdy_next;
      wrdy_reg   <= wrdy_next;
      bvalid_reg <= bvalid_next;
      remap_reg  <= remap_next;
      pad_reg    <= pad_next;
      for (int i = 0; i < 4; i++) begin
        src_reg[i] <= src_next[i];
      end
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************

  // next read response: address taken only while no data is pending
  always_comb begin
    logic [7:0] ra;
    int         idx;
    ra          = {s_axi_araddr[7:2], 2'b00};
    idx         = src_index(ra);
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg) begin
      if (s_axi_rready) begin
        rvalid_next = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      rvalid_next = 1'b1;
      rresp_next  = `SCB_RESP_OKAY;
      // reserved bits read zero
      if (ra == `SCB_OFS_REMAP) begin
        rdata_next = {{(32-`SCB_REMAP_W){1'b0}}, remap_reg};
      end else if (ra == `SCB_OFS_PAD) begin
        rdata_next = {15'h0000, pad_reg, 16'h0000};
      end else if (idx >= 0) begin
        rdata_next = {16'h0000, src_reg[idx[1:0]]};  // undefined codes read back
      end else begin
        rdata_next = `SCB_RST_WORD;
        rresp_next = `SCB_RESP_SLVERR;
      end
    end
    // ready again once no read data is pending
    arrdy_next = !rvalid_next;
  end

  // register read-path state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= `SCB_RST_WORD;
      rresp_reg  <= `SCB_RESP_OKAY;
      arrdy_reg  <= 1'b1;
    end else if (clk_en) begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
      arrdy_reg  <= arrdy_next;
    end
  end

  // ****************************************************************
  // outputs to decoder, interrupt logic and pads
  // ****************************************************************

  // decode remap, route interrupt lines and set pad drive
  always_comb begin
    logic [`SCB_SEL_W-1:0] sel;
    sel = `SCB_SEL_PORT_A;
    // low bit clear gives main flash whatever the high bit
    if (!remap_reg[0]) begin
      map_next = SCB_MAP_MAIN_FLASH;
    end else if (!remap_reg[1]) begin
      map_next = SCB_MAP_SYS_FLASH;
    end else begin
      map_next = SCB_MAP_RAM;
    end
    for (int n = 0; n < LINES; n++) begin
      sel = src_reg[n / 4][`SCB_SEL_W*(n % 4) +: `SCB_SEL_W];
      if (sel == `SCB_SEL_PORT_A) begin
        irq_next[n] = port_a_pin[n];
      end else if (sel == `SCB_SEL_PORT_B) begin
        irq_next[n] = port_b_pin[n];
      end else begin
        irq_next[n] = 1'b0;
      end
    end
    // push-pull lets the controller drive the clock high itself
    scl_hi_next = pad_reg;
  end

  // register outputs, valid from the edge after the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      map_reg    <= SCB_MAP_MAIN_FLASH;
      irq_reg    <= '0;
      scl_hi_reg <= 1'b0;
    end else if (clk_en) begin
      map_reg    <= map_next;
      irq_reg    <= irq_next;
      scl_hi_reg <= scl_hi_next;
    end
  end

  // ****************************************************************
  // port drives
  // ****************************************************************
  assign s_axi_awready          = awrdy_reg;
  assign s_axi_wready           = wrdy_reg;
  assign s_axi_bvalid           = bvalid_reg;
  assign s_axi_bresp            = bresp_reg;
  assign s_axi_arready          = arrdy_reg;
  assign s_axi_rvalid           = rvalid_reg;
  assign s_axi_rdata            = rdata_reg;
  assign s_axi_rresp            = rresp_reg;
  assign boot_area_map          = map_reg;
  assign i2c_pad_drive_select   = pad_reg;
  assign i2c_scl_drive_high     = scl_hi_reg;
  assign irq_line_source_select = irq_reg;

endmodule

//--- logic/scb_cfg.svh
// constants for the system configuration register bank
// assumes: included by bare name from the package and the bench
`ifndef SCB_CFG_SVH
`define SCB_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SCB_OFS_REMAP    8'h00
`define SCB_OFS_SRC0     8'h08
`define SCB_OFS_SRC1     8'h0C
`define SCB_OFS_SRC2     8'h10
`define SCB_OFS_SRC3     8'h14
`define SCB_OFS_PAD      8'h18

// ****************************************************************
// field layout and reset values
// ****************************************************************
`define SCB_REMAP_W      2
`define SCB_SRC_W        16
`define SCB_SEL_W        4
`define SCB_PAD_BIT      16
`define SCB_RST_WORD     32'h0000_0000
`define SCB_SEL_PORT_A   4'h0
`define SCB_SEL_PORT_B   4'h1

// ****************************************************************
// bus responses
// ****************************************************************
`define SCB_RESP_OKAY    2'h0
`define SCB_RESP_SLVERR  2'h2

`endif

//--- logic/scb_pkg.sv
// types shared by the system configuration register bank
// assumes: scb_cfg.svh is on the include path
`include "scb_cfg.svh"

package scb_pkg;

  // ****************************************************************
  // memory placed at address zero
  // ****************************************************************
  typedef enum logic [2:0] {
    SCB_MAP_MAIN_FLASH = 3'h1,  // main flash
    SCB_MAP_SYS_FLASH  = 3'h2,  // system flash
    SCB_MAP_RAM        = 3'h4   // on-chip ram
  } scb_map_t;

  // ****************************************************************
  // write channel states
  // ****************************************************************
  typedef enum logic [1:0] {
    SCB_WR_IDLE = 2'h1,  // collecting address and data
    SCB_WR_RESP = 2'h2   // response offered
  } scb_wr_state_t;

endpackage
